// file: counter_defs.vh
// Shared constants for the six-decade counter and display scanner
`ifndef COUNTER_DEFS_VH
`define COUNTER_DEFS_VH

// Clock and interdigit blanking timing
`define CLK_PERIOD_NS 16'h000A
`define BLANK_TIME_NS 16'h1388
`define BLANK_CYCLES (`BLANK_TIME_NS / `CLK_PERIOD_NS)

// Register word index (byte address = index * 4)
`define REG_CTRL 6'h00
`define REG_COUNT 6'h01
`define REG_LATCH 6'h02
`define REG_SCAN 6'h03
`define REG_BLANK 6'h04

// Control register fields and reset value
`define CTRL_BCD_MODE 0
`define CTRL_LZB_DIS 1
`define CTRL_SOFT_CLR 2
`define CTRL_RESET 2'h1

// Scan status fields
`define SCAN_BLANK_BIT 6
`define SCAN_LOAD_BIT 7
`define SCAN_HOME_BIT 8

// BCD digit limits
`define BCD_NINE 4'h9
`define BCD_ZERO 4'h0
`define NUM_DECADES 6

`endif

// file: bcd_decade.v
// One BCD decade of the up/down counter with clear and parallel load
`default_nettype none

module bcd_decade (
  input wire clk_i,
  input wire rst_i,
  input wire clear_i,
  input wire load_i,
  input wire [3:0] load_val_i,
  input wire step_i,
  input wire up_i,
  input wire carry_in_i,
  output reg [3:0] digit_o
);

`include "counter_defs.vh"

  // Clear beats load, load beats counting
  always @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      digit_o <= `BCD_ZERO;
    end else if (load_i) begin
      digit_o <= (load_val_i > `BCD_NINE) ? `BCD_NINE : load_val_i; // Keep decade in range
    end else if (step_i && carry_in_i) begin
      if (up_i) begin
        digit_o <= (digit_o == `BCD_NINE) ? `BCD_ZERO : digit_o + 4'h1;
      end else begin
        digit_o <= (digit_o == `BCD_ZERO) ? `BCD_NINE : digit_o - 4'h1;
      end
    end
  end

endmodule

`default_nettype wire

// file: scan_sequencer.v
// Divide-by-six Johnson counter that selects the scanned digit
`default_nettype none

module scan_sequencer (
  input wire clk_i,
  input wire rst_i,
  input wire advance_i,
  input wire home_i,
  output wire [5:0] sel_o,
  output wire [5:0] next_sel_o
);

  localparam [2:0] J_MSD = 3'h0;

  reg [2:0] john;

  // Johnson state to one-hot digit, bit 5 is the most significant digit
  function [5:0] decode;
    input [2:0] j;
    begin
      case (j)
        3'h0: decode = 6'h20;
        3'h1: decode = 6'h10;
        3'h3: decode = 6'h08;
        3'h7: decode = 6'h04;
        3'h6: decode = 6'h02;
        3'h4: decode = 6'h01;
        default: decode = 6'h20;
      endcase
    end
  endfunction

  // Twisted ring: shift left, feed back inverted top bit
  always @(posedge clk_i) begin
    if (rst_i || home_i) begin
      john <= J_MSD;
    end else if (advance_i) begin
      john <= {john[1:0], ~john[2]};
    end
  end

  assign sel_o = decode(john);
  assign next_sel_o = decode({john[1:0], ~john[2]});

endmodule

`default_nettype wire

// file: updown_counter_scan.v
// Six-decade BCD up/down counter with output latch, display scan and Wishbone registers
//
// Decided for this implementation: the register offsets and the Wishbone slave port.
`default_nettype none

module updown_counter_scan (
  input wire clk_i,
  input wire rst_i,
  input wire count_i,
  input wire inhibit_i,
  input wire up_i,
  input wire clear_i,
  input wire store_i,
  input wire load_i,
  input wire [3:0] bcd_in_i,
  input wire scan_i,
  input wire scan_home_n_i,
  output reg [5:0] digit_o,
  output reg [6:0] seg_o,
  output reg [3:0] bcd_o,
  output reg zero_o,
  output reg carry_o,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o
);

`include "counter_defs.vh"

  localparam [2:0] ST_SHOW = 3'h1;
  localparam [2:0] ST_DWELL = 3'h2;
  localparam [2:0] ST_BLANK = 3'h4;
  localparam [15:0] BLANK_DEF = `BLANK_CYCLES;

  // Pin synchronisers: stage one feeds only stage two
  reg [12:0] pin_s1;
  reg [12:0] pin_s2;
  reg cnt_prev;
  reg scan_prev;

  reg [1:0] ctrl;
  reg soft_clr;
  reg [15:0] blank_len;
  reg [15:0] blank_cnt;
  reg [2:0] state;
  reg [23:0] latch;
  reg inh_armed;
  reg dir_q;
  reg eval_pend;
  reg eval_up;
  reg load_req;
  reg [5:0] load_target;

  wire cnt_s = pin_s2[0];
  wire inh_s = pin_s2[1];
  wire up_s = pin_s2[2];
  wire clr_s = pin_s2[3];
  wire store_s = pin_s2[4];
  wire load_s = pin_s2[5];
  wire [3:0] bcd_s = pin_s2[9:6];
  wire scan_s = pin_s2[10];
  wire home_s = ~pin_s2[11];

  wire [23:0] count;
  wire [6:0] en;
  wire [5:0] sel;
  wire [5:0] next_sel;
  wire count_rise = cnt_s & ~cnt_prev;
  wire count_fall = ~cnt_s & cnt_prev;
  wire scan_rise = scan_s & ~scan_prev;
  wire scan_fall = ~scan_s & scan_prev;
  wire do_count;
  wire dir_now;
  wire strobe_rise;
  wire strobe_fall;
  wire clear_all;
  wire load_active;
  wire bus_req = cyc_i & stb_i & ~ack_o;
  wire [15:0] blank_last = (blank_len == 16'h0000) ? 16'h0000 : blank_len - 16'h0001;

  // Pick the BCD digit of a six-digit word under a one-hot select
  function [3:0] pick_digit;
    input [23:0] word;
    input [5:0] onehot;
    integer k;
    begin
      pick_digit = `BCD_ZERO;
      for (k = 0; k < `NUM_DECADES; k = k + 1) begin
        if (onehot[k]) begin
          pick_digit = word[4*k +: 4];
        end
      end
    end
  endfunction

  // True when the selected digit and every higher one are zero, LSD excluded
  function lead_zero;
    input [23:0] word;
    input [5:0] onehot;
    integer k;
    reg seen;
    begin
      seen = 1'b0;
      lead_zero = 1'b1;
      for (k = `NUM_DECADES - 1; k >= 0; k = k - 1) begin
        if (!seen && word[4*k +: 4] != `BCD_ZERO) begin
          lead_zero = 1'b0;
        end
        if (onehot[k]) begin
          seen = 1'b1;
        end
      end
      if (onehot[0]) begin
        lead_zero = 1'b0;
      end
    end
  endfunction

  // BCD to segments gfedcba, active high
  function [6:0] seg7;
    input [3:0] d;
    begin
      case (d)
        4'h0: seg7 = 7'h3F;
        4'h1: seg7 = 7'h06;
        4'h2: seg7 = 7'h5B;
        4'h3: seg7 = 7'h4F;
        4'h4: seg7 = 7'h66;
        4'h5: seg7 = 7'h6D;
        4'h6: seg7 = 7'h7D;
        4'h7: seg7 = 7'h07;
        4'h8: seg7 = 7'h7F;
        4'h9: seg7 = 7'h6F;
        default: seg7 = 7'h00;
      endcase
    end
  endfunction

  // Two-stage synchronisers for every pin input
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1 <= 13'h0800;
      pin_s2 <= 13'h0800;
      cnt_prev <= 1'b0;
      scan_prev <= 1'b0;
    end else begin
      pin_s1 <= {1'b0, scan_home_n_i, scan_i, bcd_in_i, load_i, store_i, clear_i, up_i, inhibit_i, count_i};
      pin_s2 <= pin_s1;
      cnt_prev <= cnt_s;
      scan_prev <= scan_s;
    end
  end

  // Count now if inhibit is low at the edge or drops later in the high phase
  assign do_count = (count_rise & ~inh_s) | (inh_armed & cnt_s & ~inh_s);
  assign dir_now = count_rise ? up_s : dir_q;
  assign clear_all = clr_s | soft_clr;
  assign load_active = load_req | load_s;

  // Inhibit tracking across the count pulse high phase
  always @(posedge clk_i) begin
    if (rst_i) begin
      inh_armed <= 1'b0;
      dir_q <= 1'b1;
    end else begin
      if (count_rise) begin
        dir_q <= up_s;
      end
      if (do_count || count_fall) begin
        inh_armed <= 1'b0;
      end else if (count_rise && inh_s) begin
        inh_armed <= 1'b1;
      end
    end
  end

  // Look-ahead carry: a decade steps when all lower ones sit at the limit
  assign en[0] = 1'b1;
  genvar g;
  generate
    for (g = 0; g < `NUM_DECADES; g = g + 1) begin : decades
      assign en[g+1] = en[g] & (dir_now ? (count[4*g +: 4] == `BCD_NINE) : (count[4*g +: 4] == `BCD_ZERO));
      bcd_decade u_decade (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(clear_all),
        .load_i(strobe_fall & load_target[g]),
        .load_val_i(bcd_s),
        .step_i(do_count),
        .up_i(dir_now),
        .carry_in_i(en[g]),
        .digit_o(count[4*g +: 4])
      );
    end
  endgenerate

  // Zero and carry are judged one cycle after the count from the new value
  always @(posedge clk_i) begin
    if (rst_i) begin
      eval_pend <= 1'b0;
      eval_up <= 1'b1;
      zero_o <= 1'b0;
      carry_o <= 1'b0;
    end else begin
      eval_pend <= do_count; // Only a real step is judged, so an inhibited pulse never raises carry
      if (do_count) begin
        eval_up <= dir_now;
      end
      if (load_active) begin
        carry_o <= 1'b0;
      end else if (eval_pend && (eval_up ? count == 24'h000000 : count == 24'h999999)) begin
        carry_o <= 1'b1;
      end else if (count_fall) begin
        carry_o <= 1'b0;
      end
      if (load_active || !ctrl[`CTRL_BCD_MODE]) begin
        zero_o <= 1'b0;
      end else if (eval_pend) begin
        zero_o <= (count == 24'h000000);
      end
    end
  end

  // Output latch: transparent while store is low, untouched by clear
  always @(posedge clk_i) begin
    if (rst_i) begin
      latch <= 24'h000000;
    end else if (!store_s) begin
      latch <= count;
    end
  end

  scan_sequencer u_scan (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .advance_i(scan_rise & ~home_s & (state == ST_DWELL)),
    .home_i(home_s),
    .sel_o(sel),
    .next_sel_o(next_sel)
  );

  assign strobe_fall = (state == ST_SHOW) & scan_fall & ~home_s;
  assign strobe_rise = (state == ST_BLANK) & (blank_cnt >= blank_last) & ~home_s;

  // Scan timing: lit, low dwell of the scan input, then blank_len clocks of blanking
  always @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_SHOW;
      blank_cnt <= 16'h0000;
    end else if (home_s) begin
      state <= ST_SHOW;
      blank_cnt <= 16'h0000;
    end else begin
      case (state)
        ST_SHOW: begin
          if (scan_fall) begin
            state <= ST_DWELL;
          end
        end
        ST_DWELL: begin
          if (scan_rise) begin
            state <= ST_BLANK;
            blank_cnt <= 16'h0000;
          end
        end
        ST_BLANK: begin
          if (strobe_rise) begin
            state <= ST_SHOW;
          end else begin
            blank_cnt <= blank_cnt + 16'h0001;
          end
        end
        default: begin
          state <= ST_SHOW;
        end
      endcase
    end
  end

  // Load request latched until a strobe rises with load released
  always @(posedge clk_i) begin
    if (rst_i) begin
      load_req <= 1'b0;
      load_target <= 6'h00;
    end else begin
      if (load_s) begin
        load_req <= 1'b1;
      end else if (strobe_rise) begin
        load_req <= 1'b0;
      end
      if (strobe_rise) begin
        load_target <= load_active ? sel : 6'h00;
      end else if (strobe_fall) begin
        load_target <= 6'h00; // Data taken at the strobe fall
      end
    end
  end

  // Display outputs, all registered
  always @(posedge clk_i) begin
    if (rst_i) begin
      digit_o <= 6'h00;
      seg_o <= 7'h00;
      bcd_o <= 4'h0;
    end else begin
      digit_o <= (home_s || (state == ST_SHOW && !scan_fall)) ? sel : 6'h00;
      if (home_s || state != ST_SHOW || scan_fall) begin
        seg_o <= 7'h00;
      end else if (!ctrl[`CTRL_LZB_DIS] && lead_zero(latch, sel)) begin
        seg_o <= 7'h00; // Leading zeros dark unless disabled
      end else begin
        seg_o <= seg7(pick_digit(latch, sel));
      end
      if (home_s) begin
        bcd_o <= pick_digit(latch, sel);
      end else if (strobe_fall) begin
        bcd_o <= pick_digit(latch, next_sel);
      end
    end
  end

  // Wishbone slave: one wait state, unmapped words read zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
      ctrl <= `CTRL_RESET;
      soft_clr <= 1'b0;
      blank_len <= BLANK_DEF;
    end else begin
      ack_o <= bus_req;
      soft_clr <= 1'b0;
      dat_o <= 32'h00000000;
      if (bus_req && we_i) begin
        case (adr_i[7:2])
          `REG_CTRL: begin
            if (sel_i[0]) begin
              ctrl <= dat_i[1:0];
              soft_clr <= dat_i[`CTRL_SOFT_CLR];
            end
          end
          `REG_BLANK: begin
            if (sel_i[0]) begin
              blank_len[7:0] <= dat_i[7:0];
            end
            if (sel_i[1]) begin
              blank_len[15:8] <= dat_i[15:8];
            end
          end
          default: begin
            ctrl <= ctrl;
          end
        endcase
      end else if (bus_req) begin
        case (adr_i[7:2])
          `REG_CTRL: dat_o <= {30'h00000000, ctrl};
          `REG_COUNT: dat_o <= {8'h00, count};
          `REG_LATCH: dat_o <= {8'h00, latch};
          `REG_SCAN: dat_o <= {23'h000000, home_s, load_active, state != ST_SHOW, digit_o};
          `REG_BLANK: dat_o <= {16'h0000, blank_len};
          default: dat_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// file: updown_counter_scan_checker.sv
// Port-level assertions for the six-decade counter and display scanner
`default_nettype none
module updown_counter_scan_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic count_i,
  input wire logic store_i,
  input wire logic load_i,
  input wire logic scan_home_n_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic [5:0] digit_o,
  input wire logic [6:0] seg_o,
  input wire logic [3:0] bcd_o,
  input wire logic zero_o,
  input wire logic carry_o,
  input wire logic ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [5:0] last;
  // Last strobe shown, so the next one can be predicted
  always @(posedge clk_i) begin
    if (rst_i)
      last <= 6'h00;
    else if (|digit_o)
      last <= digit_o;
  end
  strobe_onehot_a: assert property ($onehot0(digit_o)) else $error("strobes not one-hot");
  blank_seg_a: assert property (digit_o == 6'h00 |-> seg_o == 7'h00) else $error("segments lit in blank");
  home_hold_a: assert property (!scan_home_n_i [*6] |=> digit_o == 6'h20 && seg_o == 7'h00)
    else $error("home not held at top digit");
  scan_order_a: assert property ($rose(|digit_o) && scan_home_n_i && last != 6'h00
    |-> digit_o == ((last == 6'h01) ? 6'h20 : (last >> 1))) else $error("strobe order wrong");
  ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
  ack_resp_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("bus not answered");
  load_quiet_a: assert property (load_i [*5] |=> !carry_o && !zero_o) else $error("flag during load");
  carry_fall_a: assert property (!count_i [*8] |-> !carry_o) else $error("carry outlived pulse");
  bcd_settle_a: assert property ($rose(|digit_o) && store_i && scan_home_n_i |-> $stable(bcd_o))
    else $error("digit data moved at strobe");
  carry_seen_c: cover property ($rose(carry_o));
  zero_seen_c: cover property ($rose(zero_o));
  home_seen_c: cover property ($fell(scan_home_n_i));
endmodule
bind updown_counter_scan updown_counter_scan_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .count_i(count_i),
  .store_i(store_i), .load_i(load_i), .scan_home_n_i(scan_home_n_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .digit_o(digit_o), .seg_o(seg_o), .bcd_o(bcd_o), .zero_o(zero_o), .carry_o(carry_o), .ack_o(ack_o));
`default_nettype wire

// file: scan_partner.sv
// External scan oscillator and thumbwheel diode matrix
`default_nettype none
module scan_partner #(parameter int HI = 20, parameter int LO = 8) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [5:0] digit_o,
  output logic scan_i,
  output logic [3:0] bcd_in_i
);
  timeunit 1ns;
  timeprecision 1ps;
  int ph;
  // Free-running oscillator; the low dwell lengthens blanking
  always @(posedge clk_i) begin
    if (rst_i || ph == HI + LO - 1)
      ph <= 0;
    else
      ph <= ph + 1;
  end
  assign scan_i = (ph < HI);
  // Strobe k reads k+1; pulldowns give zero between strobes
  always @* begin
    bcd_in_i = 4'h0;
    for (int k = 0; k < 6; k++)
      if (digit_o[k])
        bcd_in_i = 4'(k + 1);
  end
endmodule
`default_nettype wire

// file: updown_counter_scan_bench.sv
// Self-checking bench for the six-decade counter and scanner
`default_nettype none
module updown_counter_scan_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_i = 1, count_i = 0, inhibit_i = 0, up_i = 1, clear_i = 0, store_i = 0, load_i = 0;
  logic scan_home_n_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, zmode = 1;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0;
  wire scan_i, zero_o, carry_o, ack_o;
  wire [5:0] digit_o;
  wire [6:0] seg_o;
  wire [3:0] bcd_o, bcd_in_i;
  wire [31:0] dat_o;
  int n_fail = 0, n_compared = 0, val = 0, lat, n, seed = 32'h84ef;
  logic [31:0] rq[$], cq[$];
  always #5 clk_i = ~clk_i;
  updown_counter_scan u_updown_counter_scan (.clk_i(clk_i), .rst_i(rst_i), .count_i(count_i),
    .inhibit_i(inhibit_i), .up_i(up_i), .clear_i(clear_i), .store_i(store_i), .load_i(load_i),
    .bcd_in_i(bcd_in_i), .scan_i(scan_i), .scan_home_n_i(scan_home_n_i), .digit_o(digit_o), .seg_o(seg_o),
    .bcd_o(bcd_o), .zero_o(zero_o), .carry_o(carry_o), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o));
  scan_partner u_scan_partner (.clk_i(clk_i), .rst_i(rst_i), .digit_o(digit_o), .scan_i(scan_i),
    .bcd_in_i(bcd_in_i));
  function automatic logic [23:0] bcd(input int v);
    for (int i = 0; i < 6; i++) begin
      bcd[i*4 +: 4] = 4'(v % 10);
      v = v / 10;
    end
  endfunction
  task finish_test;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      n_fail++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  // One classic cycle; reads leave their expectation behind
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    int t;
    t = 0;
    if (!w)
      rq.push_back(e);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1 && t < 50) begin
      t++;
      @(posedge clk_i);
    end
    if (t >= 50)
      n_fail++;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // Direction and inhibit settle well before the rise
  task pulse(input logic u, input logic inh);
    up_i <= u;
    inhibit_i <= inh;
    repeat (80) @(posedge clk_i);
    count_i <= 1'b1;
    if (!inh)
      val = u ? (val + 1) % 1000000 : (val + 999999) % 1000000;
    cq.push_back({30'h0, !inh && val == (u ? 0 : 999999), !inh && zmode && val == 0});
    repeat (10) @(posedge clk_i);
    count_i <= 1'b0;
    repeat (10) @(posedge clk_i);
  endtask
  // Read data against the oldest note
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0)
      check(dat_o, rq.pop_front());
  end
  // Flags judged while the pulse is still high
  always @(negedge count_i) begin
    if (cq.size() > 0)
      check({30'h0, carry_o, zero_o}, cq.pop_front());
  end
  initial begin
    #100000;
    n_fail++;
    finish_test;
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    bus(0, 8'h00, 32'h0, 32'h1);
    bus(0, 8'h10, 32'h0, 32'h1F4);
    bus(1, 8'h3C, 32'hFFFF, 32'h0);
    bus(0, 8'h3C, 32'h0, 32'h0);
    bus(1, 8'h10, 32'h4, 32'h0);
    bus(1, 8'h04, 32'h123, 32'h0);
    bus(0, 8'h04, 32'h0, 32'h0);
    pulse(0, 0);
    pulse(1, 0);
    n = 3 + ($random(seed) & 7);
    for (int i = 0; i < n; i++)
      pulse(1, 0);
    pulse(1, 1);
    bus(0, 8'h04, 32'h0, {8'h0, bcd(val)});
    // Store holds the display copy while counting and clearing
    store_i <= 1'b1;
    lat = val;
    pulse(0, 0);
    pulse(0, 0);
    bus(0, 8'h04, 32'h0, {8'h0, bcd(val)});
    bus(0, 8'h08, 32'h0, {8'h0, bcd(lat)});
    clear_i <= 1'b1;
    repeat (200) @(posedge clk_i);
    clear_i <= 1'b0;
    val = 0;
    bus(0, 8'h04, 32'h0, 32'h0);
    bus(0, 8'h08, 32'h0, {8'h0, bcd(lat)});
    store_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    bus(0, 8'h08, 32'h0, 32'h0);
    // Load spans several scans so every decade sees a strobe
    load_i <= 1'b1;
    repeat (600) @(posedge clk_i);
    load_i <= 1'b0;
    repeat (400) @(posedge clk_i);
    val = 654321;
    bus(0, 8'h04, 32'h0, {8'h0, bcd(val)});
    pulse(1, 0);
    scan_home_n_i <= 1'b0;
    repeat (60) @(posedge clk_i);
    check(digit_o, 32'h20);
    check(bcd_o, {28'h0, bcd(val) >> 20});
    check(seg_o, 32'h0);
    scan_home_n_i <= 1'b1;
    repeat (300) @(posedge clk_i);
    bus(0, 8'h04, 32'h0, {8'h0, bcd(val)});
    // Software clear in seven-segment mode: decades drop, zero stays dark
    bus(1, 8'h00, 32'h6, 32'h0);
    val = 0;
    zmode = 0;
    bus(0, 8'h04, 32'h0, 32'h0);
    bus(0, 8'h00, 32'h0, 32'h2);
    pulse(0, 0);
    pulse(1, 0);
    finish_test;
  end
endmodule
`default_nettype wire
